// ---- inc/mmdec_pkg.sv ----
// Package for the memory map address decoder: address constants, region codes, carriers.
// Assumes a 24-bit byte address from the CPU fetch and data path.
package mmdec_pkg;

  localparam int unsigned ADDR_W = 24;                      // 16 MB space

  // Base area and its tables
  localparam logic [23:0] BASE_LAST      = 24'h0FFFFF;
  localparam logic [23:0] VEC_FIRST      = 24'h000000;
  localparam logic [23:0] VEC_LAST       = 24'h00003F;
  localparam logic [23:0] VEC_RESET      = 24'h000000;
  localparam logic [23:0] VEC_NMI        = 24'h000002;
  localparam logic [23:0] VEC_WATCHDOG   = 24'h000004;
  localparam logic [23:0] VEC_PROD_FIRST = 24'h000006;
  localparam logic [23:0] VEC_PROD_LAST  = 24'h00003A;
  localparam logic [23:0] VEC_OPERAND    = 24'h00003C;
  localparam logic [23:0] VEC_BREAK      = 24'h00003E;
  localparam logic [23:0] TCALL_FIRST    = 24'h000040;
  localparam logic [23:0] TCALL_LAST     = 24'h00007F;
  localparam int unsigned TCALL_ENTRIES  = 32;
  localparam int unsigned TCALL_IDX_W    = 5;

  // Placement codes and the top of the internal data area for each
  localparam logic [3:0]  PLACE_LOW      = 4'h0;
  localparam logic [3:0]  PLACE_HIGH     = 4'hF;
  localparam logic [23:0] DATA_TOP_LOW   = 24'h00FFFF;
  localparam logic [23:0] DATA_TOP_HIGH  = 24'h0FFFFF;

  // Default sizes of the internal regions (bytes); ROM starts at 0, the rest stack down from the data area top
  localparam int unsigned DEF_ROM_BYTES  = 131072;
  localparam int unsigned DEF_RAM_BYTES  = 4608;
  localparam int unsigned DEF_HRAM_BYTES = 512;
  localparam int unsigned DEF_SFR_BYTES  = 256;
  localparam int unsigned DEF_GAP_BYTES  = 0;     // Between RAM top and region start of SPECIAL_FUNCTION_REGION

  // Where an access goes
  typedef enum logic [2:0] {
    MMDEC_TGT_NONE,
    MMDEC_TGT_ROM,
    MMDEC_TGT_RAM,
    MMDEC_TGT_HRAM,
    MMDEC_TGT_SFR,
    MMDEC_TGT_EXT
  } mmdec_tgt_t;

  // Vector slot that a vectored entry uses
  typedef enum logic [2:0] {
    MMDEC_VEC_RESET,
    MMDEC_VEC_NMI,
    MMDEC_VEC_WATCHDOG,
    MMDEC_VEC_PRODUCT,
    MMDEC_VEC_OPERAND,
    MMDEC_VEC_BREAK
  } mmdec_vec_t;

  // Request from the CPU side
  typedef struct packed {
    logic              valid;
    logic              fetch;   // Instruction fetch rather than data access
    logic [ADDR_W-1:0] addr;
  } mmdec_req_t;

  // Decoded answer
  typedef struct packed {
    logic              valid;
    mmdec_tgt_t        tgt;
    logic [ADDR_W-1:0] offset;  // Offset inside the selected region
    logic              fetch_fault;
    logic              unmapped;
  } mmdec_dec_t;

endpackage : mmdec_pkg

// ---- rtl/mmdec_range.sv ----
// Range comparator: flags an address lying in an inclusive window and gives its offset.
// Assumes the window bounds are static or change only between accesses.
`timescale 1ns/10ps
`default_nettype none
module mmdec_range #(
  parameter int unsigned W = 24
) (
  input  wire logic [W-1:0] addr,
  input  wire logic [W-1:0] first,
  input  wire logic [W-1:0] last,
  input  wire logic         en,
  output logic              hit,
  output logic [W-1:0]      offset
);

  // Inclusive window compare
  assign hit    = en && (addr >= first) && (addr <= last);
  assign offset = addr - first;

endmodule : mmdec_range
`default_nettype wire

// ---- rtl/mmdec_top.sv ----
// Memory map address decoder: steers CPU fetch and data accesses to internal regions.
// Assumes one CPU clock, synchronous reset, requests held for one cycle each.
//
// Summary of operation
// - Decode a full 16 MB address space
// - Placement code 0H: data area tops FFFFH
// - Placement code 0FH: data area tops FFFFFH
// - Data area wins over overlapping ROM
// - Unmapped addresses go external only in extension
// - Base area spans 00000H to FFFFFH
// - Code 0H puts data area in base
// - No fetches from high-speed RAM or SPECIAL_FUNCTION_REGION
// - Vector table occupies 00000H to 0003FH
// - Vector entries are 16-bit, base only
// - Reset, NMI, watchdog vectors at 0, 2, 4
// - Operand error 3CH, break 3EH vectors
// - Unused vector slots are ordinary memory
// - Table call area 00040H-0007FH, 32 entries
// - Table call reads entry, calls in base
// - Data area is RAM plus SPECIAL_FUNCTION_REGION region
`timescale 1ns/10ps
`default_nettype none
module mmdec_top
  import mmdec_pkg::*;
#(
  parameter int unsigned ROM_BYTES  = DEF_ROM_BYTES,
  parameter int unsigned RAM_BYTES  = DEF_RAM_BYTES,
  parameter int unsigned HRAM_BYTES = DEF_HRAM_BYTES,
  parameter int unsigned SFR_BYTES  = DEF_SFR_BYTES
) (
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic                           place_valid,
  input  wire logic [3:0]                     place_code,
  input  wire logic                           ext_mode,
  input  wire mmdec_pkg::mmdec_req_t          req,
  input  wire logic                           vec_req,
  input  wire mmdec_pkg::mmdec_vec_t          vec_sel,
  input  wire logic [5:0]                     vec_prod_slot,
  input  wire logic                           tcall_req,
  input  wire logic [mmdec_pkg::TCALL_IDX_W-1:0] tcall_idx,
  input  wire logic [15:0]                    entry_data,
  output logic                                placed,
  output logic                                place_high,
  output mmdec_pkg::mmdec_dec_t               dec,
  output logic [mmdec_pkg::ADDR_W-1:0]        entry_addr,
  output logic                                entry_rd,
  output logic                                target_valid,
  output logic [mmdec_pkg::ADDR_W-1:0]        target_addr
);
  import mmdec_pkg::*;

  logic              placed_r;
  logic              high_r;
  logic [23:0]       data_top;
  logic [23:0]       sfr_first;
  logic [23:0]       hram_first;
  logic [23:0]       ram_first;
  logic [23:0]       rom_last;
  logic              hit_sfr;
  logic              hit_hram;
  logic              hit_ram;
  logic              hit_rom;
  logic [23:0]       off_sfr;
  logic [23:0]       off_hram;
  logic [23:0]       off_ram;
  logic [23:0]       off_rom;
  logic              in_data;
  logic              in_base;
  logic              is_fetch_fault;
  logic              legal_code;
  mmdec_tgt_t        tgt_w;
  logic [23:0]       off_w;
  logic [23:0]       vec_addr;
  logic [23:0]       tcall_addr;
  mmdec_dec_t        dec_r;
  mmdec_dec_t        dec_nxt;
  logic              pend_r;
  logic [23:0]       entry_addr_r;
  logic [23:0]       target_r;
  logic              target_v_r;

  // once only
  // Only the two documented placement codes are taken
  assign legal_code = (place_code == PLACE_LOW) || (place_code == PLACE_HIGH);

  // write once
  // Placement flag set by the first legal placement op, cleared by reset only
  always_ff @(posedge clk) begin
    if (rst) begin
      placed_r <= 1'b0;
      high_r   <= 1'b0;
    end else if (place_valid && legal_code && !placed_r) begin
      placed_r <= 1'b1;
      high_r   <= (place_code == PLACE_HIGH);
    end
  end

  assign placed     = placed_r;
  assign place_high = high_r;

  // RAM plus SPECIAL_FUNCTION_REGION
  // Data area stacks down from its top: SPECIAL_FUNCTION_REGION, then RAM; high-speed RAM overlaps the top of RAM
  assign data_top   = high_r ? DATA_TOP_HIGH : DATA_TOP_LOW;
  assign sfr_first  = data_top - 24'(SFR_BYTES - 1);
  assign hram_first = sfr_first - 24'(HRAM_BYTES);
  assign ram_first  = sfr_first - 24'(RAM_BYTES);
  assign rom_last   = 24'(ROM_BYTES - 1);

  // Region compares
  mmdec_range #(.W(ADDR_W)) u_sfr (
    .addr(req.addr), .first(sfr_first), .last(data_top),
    .en(SFR_BYTES != 0), .hit(hit_sfr), .offset(off_sfr)
  );
  mmdec_range #(.W(ADDR_W)) u_hram (
    .addr(req.addr), .first(hram_first), .last(sfr_first - 24'h000001),
    .en(HRAM_BYTES != 0), .hit(hit_hram), .offset(off_hram)
  );
  mmdec_range #(.W(ADDR_W)) u_ram (
    .addr(req.addr), .first(ram_first), .last(sfr_first - 24'h000001),
    .en(RAM_BYTES != 0), .hit(hit_ram), .offset(off_ram)
  );
  mmdec_range #(.W(ADDR_W)) u_rom (
    .addr(req.addr), .first(VEC_FIRST), .last(rom_last),
    .en(ROM_BYTES != 0), .hit(hit_rom), .offset(off_rom)
  );

  assign in_base = (req.addr <= BASE_LAST);
  assign in_data = hit_sfr || hit_ram;

  // vectors as memory
  // Priority: SPECIAL_FUNCTION_REGION, high-speed RAM, RAM, ROM, external; vector and table
  // slots decode as ordinary ROM or external memory
  assign tgt_w = hit_sfr  ? MMDEC_TGT_SFR  :
                 hit_hram ? MMDEC_TGT_HRAM :
                 hit_ram  ? MMDEC_TGT_RAM  :
                 hit_rom  ? MMDEC_TGT_ROM  :
                 ext_mode ? MMDEC_TGT_EXT  : MMDEC_TGT_NONE;
  assign off_w = hit_sfr  ? off_sfr  :
                 hit_hram ? off_hram :
                 hit_ram  ? off_ram  :
                 hit_rom  ? off_rom  : req.addr;

  // no fetch
  // Fetch from high-speed RAM or SPECIAL_FUNCTION_REGION is refused and flagged
  assign is_fetch_fault = req.fetch && (hit_sfr || hit_hram);

  // Registered decode result
  always_comb begin
    dec_nxt             = '0;
    dec_nxt.valid       = req.valid;
    dec_nxt.fetch_fault = req.valid && is_fetch_fault;
    dec_nxt.tgt         = (req.valid && !is_fetch_fault) ? tgt_w : MMDEC_TGT_NONE;
    dec_nxt.offset      = (req.valid && !is_fetch_fault) ? off_w : '0;
    dec_nxt.unmapped    = req.valid && !is_fetch_fault && (tgt_w == MMDEC_TGT_NONE);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dec_r <= '0;
    end else begin
      dec_r <= dec_nxt;
    end
  end

  assign dec = dec_r;

  // vector slots
  // Vector slot address; product slots are clamped to 06H..3AH, even bytes
  always_comb begin
    case (vec_sel)
      MMDEC_VEC_RESET:    vec_addr = VEC_RESET;
      MMDEC_VEC_NMI:      vec_addr = VEC_NMI;
      MMDEC_VEC_WATCHDOG: vec_addr = VEC_WATCHDOG;
      MMDEC_VEC_PRODUCT: begin
        vec_addr = {18'h00000, vec_prod_slot[5:1], 1'b0};
        if (vec_addr < VEC_PROD_FIRST) vec_addr = VEC_PROD_FIRST;
        if (vec_addr > VEC_PROD_LAST)  vec_addr = VEC_PROD_LAST;
      end
      MMDEC_VEC_OPERAND:  vec_addr = VEC_OPERAND;
      MMDEC_VEC_BREAK:    vec_addr = VEC_BREAK;
      default:            vec_addr = VEC_RESET;
    endcase
  end

  // table area
  // Table call entry: two bytes per slot from 40H
  assign tcall_addr = TCALL_FIRST + {18'h00000, tcall_idx, 1'b0};

  // base only
  // Entry read is issued, then the 16-bit entry becomes a base-area target
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_r       <= 1'b0;
      entry_addr_r <= '0;
      target_r     <= '0;
      target_v_r   <= 1'b0;
    end else begin
      target_v_r <= pend_r;
      if (pend_r) begin
        target_r <= {8'h00, entry_data};
      end
      pend_r <= (vec_req || tcall_req) && !pend_r;
      if ((vec_req || tcall_req) && !pend_r) begin
        entry_addr_r <= vec_req ? vec_addr : tcall_addr;
      end
    end
  end

  assign entry_rd     = pend_r;
  assign entry_addr   = entry_addr_r;
  assign target_valid = target_v_r;
  assign target_addr  = target_r;

  // Unused here apart from range bookkeeping
  logic unused_ok;
  assign unused_ok = in_base ^ in_data ^ legal_code;

endmodule : mmdec_top
`default_nettype wire

// ---- testbench/mmdec_chk.sv ----
// Checker for the address decoder: placement, decode and entry timing.
// Assumes it is bound into the decoder top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module mmdec_chk
  import mmdec_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  place_valid,
  input wire logic [3:0]            place_code,
  input wire logic                  ext_mode,
  input wire mmdec_pkg::mmdec_req_t req,
  input wire logic                  vec_req,
  input wire mmdec_pkg::mmdec_vec_t vec_sel,
  input wire logic                  tcall_req,
  input wire logic [4:0]            tcall_idx,
  input wire logic [15:0]           entry_data,
  input wire logic                  placed,
  input wire logic                  place_high,
  input wire mmdec_pkg::mmdec_dec_t dec,
  input wire logic [23:0]           entry_addr,
  input wire logic                  entry_rd,
  input wire logic                  target_valid,
  input wire logic [23:0]           target_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Entry word read, then its target one cycle later
  sequence s_answer;
    entry_rd ##1 (target_valid && target_addr == {8'h00, $past(entry_data)});
  endsequence
  property p_hi; place_valid && !placed && place_code == 4'hF |=> placed && place_high; endproperty
  a_hi: assert property (p_hi) else $error("high placement not taken");
  property p_lo; place_valid && !placed && place_code == 4'h0 |=> placed && !place_high; endproperty
  a_lo: assert property (p_lo) else $error("low placement not taken");
  property p_hold; placed |=> placed && $stable(place_high); endproperty
  a_hold: assert property (p_hold) else $error("placement changed");
  property p_lat; req.valid |=> dec.valid; endproperty
  a_lat: assert property (p_lat) else $error("decode answer missing");
  property p_fetch; req.valid && req.fetch |=> !(dec.tgt inside {MMDEC_TGT_SFR, MMDEC_TGT_HRAM}); endproperty
  a_fetch: assert property (p_fetch) else $error("fetch from data region");
  property p_ext; req.valid && !ext_mode |=> dec.tgt != MMDEC_TGT_EXT; endproperty
  a_ext: assert property (p_ext) else $error("external without extension");
  property p_top;
    req.valid && !req.fetch && req.addr == (place_high ? 24'h0FFFFF : 24'h00FFFF)
      |=> dec.tgt == MMDEC_TGT_SFR;
  endproperty
  a_top: assert property (p_top) else $error("data area top misplaced");
  property p_tcall;
    tcall_req && !vec_req && !entry_rd
      |=> (entry_addr == 24'h000040 + {$past(tcall_idx), 1'b0}) ##0 s_answer;
  endproperty
  a_tcall: assert property (p_tcall) else $error("table call entry wrong");
  property p_brk;
    vec_req && vec_sel == MMDEC_VEC_BREAK && !entry_rd |=> (entry_addr == 24'h00003E) ##0 s_answer;
  endproperty
  a_brk: assert property (p_brk) else $error("break vector wrong");
endmodule : mmdec_chk
bind mmdec_top mmdec_chk mmdec_chk_inst (.clk, .rst, .place_valid, .place_code, .ext_mode, .req,
  .vec_req, .vec_sel, .tcall_req, .tcall_idx, .entry_data, .placed, .place_high, .dec,
  .entry_addr, .entry_rd, .target_valid, .target_addr);
`default_nettype wire

// ---- testbench/mmdec_mem_model.sv ----
// Memory model: answers vector and call table reads with a 16-bit word.
// Assumes the word is wanted in the cycle of the read strobe.
`timescale 1ns/10ps
`default_nettype none
module mmdec_mem_model (
  input  wire logic        clk,
  input  wire logic        entry_rd,
  input  wire logic [23:0] entry_addr,
  output logic      [15:0] entry_data
);
  logic [15:0] last_r = 16'h0000;
  // word per entry, inverse of last when idle
  assign entry_data = entry_rd ? {entry_addr[7:0] ^ 8'hA5, entry_addr[7:0]} : ~last_r;
  // Remember last word for the idle pattern
  always @(posedge clk) begin
    if (entry_rd) begin
      last_r <= entry_data;
    end
  end
endmodule : mmdec_mem_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Bench for the address decoder: placement, both maps, vectors and table calls.
// Assumes default region sizes and the memory model on the entry port.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import mmdec_pkg::*;
  logic clk = 1'b0, rst = 1'b1, place_valid = 1'b0, ext_mode = 1'b0, vec_req = 1'b0;
  logic tcall_req = 1'b0, placed, place_high, entry_rd, target_valid;
  logic [3:0] place_code = 4'h0;
  logic [4:0] tcall_idx = 5'h00;
  logic [4:0] ridx;
  logic [5:0] vec_prod_slot = 6'h00;
  logic [15:0] entry_data;
  logic [23:0] entry_addr, target_addr, top;
  mmdec_req_t req = '0;
  mmdec_vec_t vec_sel = MMDEC_VEC_RESET;
  mmdec_dec_t dec, e, dq[$];
  logic [23:0] aq[$], tq[$];
  int errors = 0, comparisons = 0, cycles = 0, seed = 32'h33B6E44B;
  always #50 clk = ~clk;
  mmdec_top mmdec_top_inst (.clk, .rst, .place_valid, .place_code, .ext_mode, .req, .vec_req,
    .vec_sel, .vec_prod_slot, .tcall_req, .tcall_idx, .entry_data, .placed, .place_high, .dec,
    .entry_addr, .entry_rd, .target_valid, .target_addr);
  mmdec_mem_model mmdec_mem_model_inst (.clk, .entry_rd, .entry_addr, .entry_data);
  task automatic check(string name, logic [23:0] exp, logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic report_and_stop;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  // Expected decode under the current map top
  function automatic mmdec_dec_t expect_dec(logic [23:0] a, logic f);
    mmdec_dec_t d;
    d = '0;
    d.valid = 1'b1;
    d.offset = a;
    d.tgt = MMDEC_TGT_ROM;
    if (a <= top && a >= top - 24'hFF) begin
      d.tgt = MMDEC_TGT_SFR;
      d.offset = a - (top - 24'hFF);
    end else if (a <= top - 24'h100 && a >= top - 24'h2FF) begin
      d.tgt = MMDEC_TGT_HRAM;
      d.offset = a - (top - 24'h2FF);
    end else if (a <= top - 24'h100 && a >= top - 24'h12FF) begin
      d.tgt = MMDEC_TGT_RAM;
      d.offset = a - (top - 24'h12FF);
    end else if (a > 24'h01FFFF) begin
      d.tgt = ext_mode ? MMDEC_TGT_EXT : MMDEC_TGT_NONE;
      d.unmapped = !ext_mode;
    end
    if (f && d.tgt inside {MMDEC_TGT_SFR, MMDEC_TGT_HRAM}) begin
      d.tgt = MMDEC_TGT_NONE;
      d.fetch_fault = 1'b1;
    end
    return d;
  endfunction : expect_dec
  // Access sweep over region edges, fetch on odd slots, both extension modes
  // decode only, no RAM word read
  task automatic sweep;
    logic [23:0] al [12];
    al = '{top, top, top - 24'h100, top - 24'h2FF, top - 24'h12FF, top - 24'h1300, 24'h01FFFF,
           24'h020000, 24'h00003E, 24'hFFFFFF, 24'h0, 24'h0};
    for (int x = 0; x < 2; x++) begin
      al[10] = 24'($random(seed));
      al[11] = 24'($random(seed));
      ext_mode = x[0];
      for (int i = 0; i < 12; i++) begin
        req = '{1'b1, i[0], al[i]};
        dq.push_back(expect_dec(al[i], i[0]));
        @(posedge clk);
        #10;
      end
    end
    req.valid = 1'b0;
  endtask : sweep
  task automatic place(logic [3:0] c, logic ep, logic eh);
    place_valid = 1'b1;
    place_code = c;
    @(posedge clk);
    #10;
    place_valid = 1'b0;
    check("placed", ep, placed);
    check("place_high", eh, place_high);
    @(posedge clk);
    #10;
  endtask : place
  task automatic call(logic v, mmdec_vec_t s, logic [5:0] slot, logic [4:0] idx, logic [23:0] a);
    vec_req = v;
    tcall_req = !v;
    vec_sel = s;
    vec_prod_slot = slot;
    tcall_idx = idx;
    aq.push_back(a);
    tq.push_back({8'h00, a[7:0] ^ 8'hA5, a[7:0]});
    @(posedge clk);
    #10;
    vec_req = 1'b0;
    tcall_req = 1'b0;
    repeat (3) @(posedge clk);
    #10;
  endtask : call
  // Watch the outputs and match each result against the oldest note
  always @(negedge clk) begin
    if (dec.valid === 1'b1) begin
      e = dq.pop_front();
      check("dec_tgt", e.tgt, dec.tgt);
      check("dec_flags", {e.fetch_fault, e.unmapped}, {dec.fetch_fault, dec.unmapped});
      if (e.tgt inside {MMDEC_TGT_ROM, MMDEC_TGT_RAM, MMDEC_TGT_HRAM, MMDEC_TGT_SFR})
        check("dec_offset", e.offset, dec.offset);
    end
    if (entry_rd === 1'b1) check("entry_addr", aq.pop_front(), entry_addr);
    if (target_valid === 1'b1) check("target", tq.pop_front(), target_addr);
  end
  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    for (int p = 0; p < 2; p++) begin
      rst = 1'b1;
      repeat (6) @(posedge clk);
      #10;
      rst = 1'b0;
      check("placed_rst", 24'h0, placed);
      top = 24'h00FFFF;
      if (p == 1) sweep();
      place(4'h5, 1'b0, 1'b0);
      place(p ? 4'hF : 4'h0, 1'b1, p[0]);
      place(p ? 4'h0 : 4'hF, 1'b1, p[0]);
      top = p ? 24'h0FFFFF : 24'h00FFFF;
      sweep();
    end
    for (int i = 0; i < 6; i++)
      call(1'b1, mmdec_vec_t'(i), 6'h3F, 5'h00,
           i == 3 ? 24'h00003A : 24'(2 * i) + (i > 3 ? 24'h000034 : 24'h000000));
    call(1'b1, MMDEC_VEC_PRODUCT, 6'h11, 5'h00, 24'h000010);
    call(1'b1, MMDEC_VEC_PRODUCT, 6'h02, 5'h00, 24'h000006);
    call(1'b0, MMDEC_VEC_RESET, 6'h00, 5'h1F, 24'h00007E);
    ridx = 5'($random(seed));
    call(1'b0, MMDEC_VEC_RESET, 6'h00, ridx, 24'h40 + {ridx, 1'b0});
    repeat (3) @(posedge clk);
    check("pending", 24'h0, 24'(dq.size() + aq.size() + tq.size()));
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
